//--- rtl/scwi_pkg.sv
package scwi_pkg;
	localparam int CMD_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 6;
	localparam int SYNC_W = 4;
	localparam int SYNC_SCLK = 0;
	localparam int SYNC_SDI = 1;
	localparam int SYNC_CS_N = 2;
	localparam int SYNC_DRDY_N = 3;
	localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
	localparam logic [CMD_W-1:0] CMD_CONT_ENTER = 8'h5c;
	localparam logic [CMD_W-1:0] CMD_CONT_EXIT = 8'h58;
	localparam logic [2:0] SEL_COMMAND = 3'h0;
	localparam logic [CNT_W-1:0] CMD_LAST_BIT = 6'h07;
	localparam logic [CNT_W-1:0] RESET_ONES = 6'h20;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic write_gate;
		logic dir_read;
		logic target_select_bit2;
		logic target_select_bit1;
		logic target_select_bit0;
		logic continuous_fetch_bit;
		logic [1:0] fixed_zero;
	} scwi_cmd_t;

	typedef struct packed {
		logic read;
		logic [2:0] select;
	} scwi_access_t;

	typedef enum logic [1:0] {ST_COMMAND, ST_WRITE, ST_READ, ST_CONT} scwi_state_t;
endpackage

//--- rtl/scwi_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pins arriving from outside the CLK domain.
module scwi_sync (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [scwi_pkg::SYNC_W-1:0] ASYNC_IN,
	input wire logic [scwi_pkg::SYNC_W-1:0] RESET_LEVEL,
	output logic [scwi_pkg::SYNC_W-1:0] SYNC_OUT
);
	import scwi_pkg::*;

	logic [SYNC_W-1:0] stage1;
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_bit
			always_ff @(posedge CLK) begin
				if (RESET) begin
					stage1[g] <= 1'b0;
					SYNC_OUT[g] <= 1'b0;
				end else if (CE) begin
					stage1[g] <= ASYNC_IN[g] ^ RESET_LEVEL[g];
					SYNC_OUT[g] <= stage1[g];
				end
			end
		end
	endgenerate
endmodule

//--- rtl/scwi_top.sv
`timescale 1ns/10ps
// How it works
// - Command word is an 8-bit register written only from the serial input.
// - Every transaction opens with a command byte; first byte from idle is that byte.
// - Stored command word picks read or write and the target register.
// - After one access completes, the interface goes back to awaiting a command, except in continuous read.
// - Power-up and every reset leave the interface awaiting a command.
// - Thirty-two consecutive ones on the serial input reset the whole part except the write shift register.
// - Command bits arrive most significant first, bit 7 leading.
// - Bits: 7 write gate, 6 direction, 5-3 select, 2 continuous read, 1-0 zero.
// - All command word bits reset to zero.
// - Select zero with a write addresses the command word itself.
// - A one in the write gate position holds the bit position until a zero.
// - Direction zero means write, direction one means read.
// - Continuous read entered by 01011100, left by 01011000 while data-ready is low.
// - Output data changes on the falling serial clock edge while chip select is low.
module scwi_top (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic SCLK,
	input wire logic SDI,
	input wire logic CS_N,
	input wire logic DRDY_N,
	input wire logic [scwi_pkg::CNT_W-1:0] ACCESS_BITS,
	input wire logic [scwi_pkg::DATA_W-1:0] RD_DATA,
	output logic DOUT,
	output logic DOUT_OE,
	output logic ACCESS_REQ,
	output scwi_pkg::scwi_access_t ACCESS,
	output logic [scwi_pkg::DATA_W-1:0] WR_DATA,
	output logic WR_STROBE,
	output scwi_pkg::scwi_cmd_t CMD_WORD,
	output logic CONT_READ,
	output logic PART_RESET
);
	import scwi_pkg::*;

	// SCLK, CS_N and DRDY_N idle high, so they are inverted through the synchroniser.
	// Its low reset value then matches the idle pins, and no false edge follows reset.
	localparam logic [SYNC_W-1:0] SYNC_INVERT = 4'hd;

	logic [SYNC_W-1:0] sync;
	logic sclk_s, sclk_q, sdi_s, cs_n_s, drdy_n_s, drdy_n_q;
	logic rise, fall, drdy_fall;
	scwi_state_t state, next_state;
	logic [CMD_W-1:0] cmd_shift, next_cmd_shift;
	logic [CNT_W-1:0] bit_cnt, next_bit_cnt, ones_cnt, next_ones_cnt;
	logic [DATA_W-1:0] wr_shift, next_wr_shift, rd_shift, next_rd_shift;
	logic load_pending, next_load_pending;
	logic next_dout, next_dout_oe, next_access_req, next_wr_strobe;
	logic next_cont_read, next_part_reset;
	logic [DATA_W-1:0] next_wr_data;
	scwi_access_t next_access;
	scwi_cmd_t next_cmd_word;
	logic [CMD_W-1:0] byte_in;
	logic last_bit;

	function automatic logic [2:0] sel_of(input scwi_cmd_t c);
		sel_of = {c.target_select_bit2, c.target_select_bit1, c.target_select_bit0};
	endfunction

	function automatic logic is_self_write(input scwi_cmd_t c);
		is_self_write = !c.dir_read && sel_of(c) == SEL_COMMAND;
	endfunction

	scwi_sync u_sync (
		.CLK(CLK),
		.RESET(RESET),
		.CE(CE),
		.ASYNC_IN({DRDY_N, CS_N, SDI, SCLK}),
		.RESET_LEVEL(SYNC_INVERT),
		.SYNC_OUT(sync)
	);

	assign sclk_s = !sync[SYNC_SCLK];
	assign sdi_s = sync[SYNC_SDI];
	assign cs_n_s = !sync[SYNC_CS_N];
	assign drdy_n_s = !sync[SYNC_DRDY_N];
	assign rise = !cs_n_s && sclk_s && !sclk_q;
	assign fall = !cs_n_s && !sclk_s && sclk_q;
	assign drdy_fall = !drdy_n_s && drdy_n_q;
	assign byte_in = {cmd_shift[CMD_W-2:0], sdi_s};
	assign last_bit = (bit_cnt + CNT_ONE) == ACCESS_BITS;

	always_comb begin
		next_state = state;
		next_cmd_shift = cmd_shift;
		next_bit_cnt = bit_cnt;
		next_ones_cnt = ones_cnt;
		next_wr_shift = wr_shift;
		next_rd_shift = rd_shift;
		next_load_pending = 1'b0;
		next_dout = DOUT;
		next_dout_oe = !cs_n_s;
		next_access_req = 1'b0;
		next_access = ACCESS;
		next_wr_data = WR_DATA;
		next_wr_strobe = 1'b0;
		next_cmd_word = CMD_WORD;
		next_cont_read = CONT_READ;
		next_part_reset = 1'b0;

		// Read data from the outer register is taken one cycle after the request,
		// left-aligned so the first bit shifted out is its most significant one.
		if (load_pending) begin
			next_rd_shift = RD_DATA << (CNT_W'(DATA_W) - ACCESS_BITS);
		end

		if (fall && (state == ST_READ || state == ST_CONT)) begin
			next_dout = rd_shift[DATA_W-1];
			next_rd_shift = {rd_shift[DATA_W-2:0], 1'b0};
		end

		if (state == ST_CONT && drdy_fall) begin
			next_access_req = 1'b1;
			next_load_pending = 1'b1;
			next_bit_cnt = '0;
		end

		if (rise) begin
			next_ones_cnt = sdi_s ? ones_cnt + CNT_ONE : '0;
			unique case (state)
				ST_COMMAND: begin
					if (bit_cnt == '0 && sdi_s) begin
						next_bit_cnt = '0;
					end else if (bit_cnt == CMD_LAST_BIT) begin
						next_bit_cnt = '0;
						next_cmd_word = scwi_cmd_t'(byte_in);
						next_access = '{read: byte_in[CMD_W-2], select: sel_of(scwi_cmd_t'(byte_in))};
						if (is_self_write(scwi_cmd_t'(byte_in))) begin
							next_state = ST_COMMAND;
						end else if (byte_in == CMD_CONT_ENTER) begin
							next_state = ST_CONT;
							next_cont_read = 1'b1;
						end else begin
							next_access_req = 1'b1;
							next_wr_shift = DATA_ZERO;
							next_load_pending = byte_in[CMD_W-2];
							next_state = byte_in[CMD_W-2] ? ST_READ : ST_WRITE;
						end
					end else begin
						next_cmd_shift = byte_in;
						next_bit_cnt = bit_cnt + CNT_ONE;
					end
				end
				ST_WRITE: begin
					next_wr_shift = {wr_shift[DATA_W-2:0], sdi_s};
					next_bit_cnt = bit_cnt + CNT_ONE;
					if (last_bit) begin
						next_wr_data = {wr_shift[DATA_W-2:0], sdi_s};
						next_wr_strobe = 1'b1;
						next_bit_cnt = '0;
						next_state = ST_COMMAND;
					end
				end
				ST_READ: begin
					next_bit_cnt = bit_cnt + CNT_ONE;
					if (last_bit) begin
						next_bit_cnt = '0;
						next_state = ST_COMMAND;
					end
				end
				ST_CONT: begin
					// The input line is watched for the exit byte while data streams out.
					next_cmd_shift = byte_in;
					next_bit_cnt = last_bit ? '0 : bit_cnt + CNT_ONE;
					if (bit_cnt[2:0] == BYTE_LAST && byte_in == CMD_CONT_EXIT && !drdy_n_s) begin
						next_state = ST_COMMAND;
						next_cont_read = 1'b0;
						next_bit_cnt = '0;
						next_cmd_word = scwi_cmd_t'(byte_in);
					end
				end
			endcase
			if (sdi_s && ones_cnt == RESET_ONES - CNT_ONE) begin
				// Whole-part reset: state returns to power-up values, except the write shift register, which is not cleared.
				next_part_reset = 1'b1;
				next_state = ST_COMMAND;
				next_cmd_word = scwi_cmd_t'(CMD_RESET);
				next_cmd_shift = CMD_RESET;
				next_bit_cnt = '0;
				next_ones_cnt = '0;
				next_cont_read = 1'b0;
				next_access_req = 1'b0;
				next_wr_strobe = 1'b0;
				next_load_pending = 1'b0;
				next_access = '0;
				next_wr_data = DATA_ZERO;
				next_rd_shift = DATA_ZERO;
				next_dout = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state <= ST_COMMAND;
			cmd_shift <= CMD_RESET;
			bit_cnt <= '0;
			ones_cnt <= '0;
			wr_shift <= DATA_ZERO;
			rd_shift <= DATA_ZERO;
			load_pending <= 1'b0;
			sclk_q <= 1'b1;
			drdy_n_q <= 1'b1;
			DOUT <= 1'b0;
			DOUT_OE <= 1'b0;
			ACCESS_REQ <= 1'b0;
			ACCESS <= '0;
			WR_DATA <= DATA_ZERO;
			WR_STROBE <= 1'b0;
			CMD_WORD <= scwi_cmd_t'(CMD_RESET);
			CONT_READ <= 1'b0;
			PART_RESET <= 1'b0;
		end else if (CE) begin
			state <= next_state;
			cmd_shift <= next_cmd_shift;
			bit_cnt <= next_bit_cnt;
			ones_cnt <= next_ones_cnt;
			wr_shift <= next_wr_shift;
			rd_shift <= next_rd_shift;
			load_pending <= next_load_pending;
			sclk_q <= sclk_s;
			drdy_n_q <= drdy_n_s;
			DOUT <= next_dout;
			DOUT_OE <= next_dout_oe;
			ACCESS_REQ <= next_access_req;
			ACCESS <= next_access;
			WR_DATA <= next_wr_data;
			WR_STROBE <= next_wr_strobe;
			CMD_WORD <= next_cmd_word;
			CONT_READ <= next_cont_read;
			PART_RESET <= next_part_reset;
		end
	end
endmodule

//--- test/scwi_assertions.sv
`timescale 1ns/10ps
module scwi_assertions (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CS_N,
	input wire logic DOUT_OE,
	input wire logic ACCESS_REQ,
	input wire scwi_pkg::scwi_access_t ACCESS,
	input wire logic WR_STROBE,
	input wire scwi_pkg::scwi_cmd_t CMD_WORD,
	input wire logic CONT_READ,
	input wire logic PART_RESET
);
	import scwi_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	AST_RST_IDLE: assert property ($fell(RESET) |-> CMD_WORD == 8'h00 && !CONT_READ)
		else $error("command word not cleared by reset");
	AST_PART_RESET: assert property (PART_RESET |-> ##[0:1] CMD_WORD == 8'h00)
		else $error("ones pattern did not clear command word");
	AST_PR_ONCE: assert property (PART_RESET |=> !PART_RESET [*8])
		else $error("part reset pulsed again too soon");
	AST_NO_SEL0_WRITE: assert property (ACCESS_REQ |-> ACCESS.read || ACCESS.select != 3'h0)
		else $error("write to select zero sent outside");
	AST_ACCESS_CMD: assert property (ACCESS_REQ |-> ACCESS == {CMD_WORD.dir_read, CMD_WORD[5:3]})
		else $error("access does not follow command word");
	AST_WR_IS_WRITE: assert property (WR_STROBE |-> !ACCESS.read && !ACCESS_REQ)
		else $error("write strobe during read access");
	AST_CS_QUIET: assert property (CS_N [*8] |-> $stable(CMD_WORD) && !WR_STROBE)
		else $error("activity while deselected");
	AST_OE_OFF: assert property (CS_N [*5] |=> !DOUT_OE)
		else $error("output driven while deselected");
	AST_CONT_ENTRY: assert property ($rose(CONT_READ) |-> CMD_WORD == 8'h5c && !ACCESS_REQ)
		else $error("continuous mode entered by wrong byte");
	cover property (ACCESS_REQ && ACCESS.read);
	cover property (WR_STROBE);
	cover property (PART_RESET);
	cover property (CONT_READ && ACCESS_REQ);
endmodule

//--- test/scwi_host.sv
`timescale 1ns/10ps
module scwi_host (
	output logic SCLK,
	output logic SDI,
	output logic CS_N,
	input wire logic DOUT
);
	logic [31:0] rx;
	initial begin
		SCLK = 1'h1;
		SDI = 1'h0;
		CS_N = 1'h1;
		rx = 32'h0000_0000;
	end
	// Output is sampled late in the high phase, since the part moves it a few clocks after the fall.
	task automatic xfer(input logic [31:0] v, input int n);
		CS_N = 1'h0;
		for (int i = n - 1; i >= 0; i--) begin
			#1 SCLK = 1'h0;
			SDI = v[i];
			#40 SCLK = 1'h1;
			#39 rx = {rx[30:0], DOUT};
		end
		#40 CS_N = 1'h1;
		SDI = 1'h0;
		// Idle gap, so a following call never lowers chip select in the step that raised it.
		#40;
	endtask
endmodule

//--- test/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
	checked++; \
	if ((a) !== (e)) begin \
		err_total++; \
		$display("BAD %0t got %h exp %h", $time, a, e); \
	end \
end
module tb;
	import scwi_pkg::*;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic ce = 1'h1;
	logic drdy_n = 1'h1;
	logic [CNT_W-1:0] bits = 6'h08;
	logic [DATA_W-1:0] rd = 32'h0000_0000;
	logic sclk, sdi, cs_n, dout, doe, acc_req, wr_stb, cont, prst;
	scwi_access_t acc, acc_seen;
	scwi_cmd_t cmd;
	logic [DATA_W-1:0] wr, wr_seen, d;
	logic [7:0] c;
	int err_total = 0, checked = 0, seed = 36002, n_req = 0, n_wr = 0, n_pr = 0, n_oe = 0, n;
	function automatic logic [31:0] mask(logic [31:0] v, int w);
		return v & ((32'h1 << w) - 32'h1);
	endfunction
	function automatic logic [7:0] mkcmd(logic dir, logic [2:0] sel, logic cr);
		return {1'h0, dir, sel, cr, 2'h0};
	endfunction
	initial forever #5 clk = ~clk;
	scwi_top u_dut (.CLK(clk), .RESET(reset), .CE(ce), .SCLK(sclk), .SDI(sdi), .CS_N(cs_n),
		.DRDY_N(drdy_n), .ACCESS_BITS(bits), .RD_DATA(rd), .DOUT(dout), .DOUT_OE(doe),
		.ACCESS_REQ(acc_req), .ACCESS(acc), .WR_DATA(wr), .WR_STROBE(wr_stb),
		.CMD_WORD(cmd), .CONT_READ(cont), .PART_RESET(prst));
	scwi_host u_host (.SCLK(sclk), .SDI(sdi), .CS_N(cs_n), .DOUT(dout));
	always @(posedge clk) begin
		if (acc_req) begin
			n_req++;
			acc_seen = acc;
		end
		if (wr_stb) begin
			n_wr++;
			wr_seen = wr;
		end
		if (prst) n_pr++;
		if (doe) n_oe++;
	end
	// Answers land a few clocks after the last serial edge; ten leaves margin.
	task automatic settle();
		repeat (10) @(negedge clk);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		reset = 1'h0;
		repeat (4) @(negedge clk);
		`CHK(cmd, 8'h00)
		`CHK(cont, 1'h0)
		`CHK(doe, 1'h0)
		// A frozen block must ignore a whole command sent while the enable is low.
		ce = 1'h0;
		u_host.xfer({24'h0, mkcmd(1'h0, 3'h0, 1'h1)}, 8);
		@(negedge clk);
		ce = 1'h1;
		settle();
		`CHK(cmd, 8'h00)
		u_host.xfer({21'h0, 3'h7, mkcmd(1'h0, 3'h0, 1'h1)}, 11);
		settle();
		`CHK(cmd, 8'h04)
		`CHK(n_req, 0)
		for (int k = 0; k < 14; k++) begin
			n = ($random(seed) & 31) + 1;
			d = $random(seed);
			bits = n[CNT_W-1:0];
			rd = d;
			c = mkcmd(k[0], 3'(k / 2 + 1), 1'h0);
			u_host.xfer({24'h0, c}, 8);
			u_host.xfer(d, n);
			settle();
			`CHK(cmd, c)
			`CHK(acc_seen, {k[0], c[5:3]})
			`CHK(n_req, k + 1)
			`CHK(n_wr, k / 2 + 1)
			if (k[0]) `CHK(mask(u_host.rx, n), mask(d, n))
			else `CHK(wr_seen, mask(d, n))
		end
		bits = 6'h08;
		u_host.xfer({24'h0, mkcmd(1'h1, 3'h3, 1'h1)}, 8);
		settle();
		`CHK(cont, 1'h1)
		drdy_n = 1'h0;
		for (int k = 0; k < 50 && n_req < 15; k++) @(negedge clk);
		`CHK(n_req, 15)
		if (n_req < 15) end_of_test();
		`CHK(acc_seen, 4'hb)
		u_host.xfer({24'h0, mkcmd(1'h1, 3'h3, 1'h0)}, 8);
		settle();
		drdy_n = 1'h1;
		`CHK(mask(u_host.rx, 8), mask(rd, 8))
		`CHK(cont, 1'h0)
		u_host.xfer(32'hffff_ffff, 32);
		settle();
		`CHK(n_pr, 1)
		`CHK(cmd, 8'h00)
		`CHK(n_oe != 0, 1'h1)
		u_host.xfer({24'h0, mkcmd(1'h0, 3'h0, 1'h1)}, 8);
		settle();
		`CHK(cmd, 8'h04)
		// A reset in mid-run must bring the command word back to its default.
		reset = 1'h1;
		repeat (2) @(negedge clk);
		reset = 1'h0;
		repeat (4) @(negedge clk);
		`CHK(cmd, 8'h00)
		`CHK(n_req, 15)
		end_of_test();
	end
endmodule
bind scwi_top scwi_assertions u_chk (.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .DOUT_OE(DOUT_OE),
	.ACCESS_REQ(ACCESS_REQ), .ACCESS(ACCESS), .WR_STROBE(WR_STROBE), .CMD_WORD(CMD_WORD),
	.CONT_READ(CONT_READ), .PART_RESET(PART_RESET));
